// ---- shared/mtd_pkg.sv ----
// Constants and types for the dual metering tone output logic
package mtd_pkg;
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_NS = 100_000;
  localparam int TICK_CYC = TICK_NS / (1_000_000_000 / CLK_HZ);
  localparam logic [11:0] TICK_MAX = 12'(TICK_CYC - 1);
  // Register byte offsets
  localparam logic [7:0] OFF_WIN_LEN = 8'h00;
  localparam logic [7:0] OFF_WIN_THR = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_INT_STAT = 8'h0c;
  localparam logic [7:0] OFF_INT_CLR = 8'h10;
  localparam logic [7:0] OFF_INT_EN = 8'h14;
  // Reset values
  localparam logic [15:0] WIN_LEN_RST = 16'h0190;
  localparam logic [15:0] ON_THR_RST = 16'h00c8;
  localparam logic [15:0] OFF_THR_RST = 16'h00c8;
  localparam logic [7:0] CFG_RST = 8'h88;
  localparam logic [2:0] FIX_SENS = 3'h0;
  // Field layout
  localparam int THR_OFF_LSB = 16;
  localparam int CFG_BAND_BIT = 3;
  localparam int CH_CFG_W = 4;
  localparam logic [3:0] SER_BITS = 4'h8;
  localparam int IRQ_W = 5;
  localparam int EV_RISE = 0;
  localparam int EV_FALL = 2;
  localparam int EV_LOAD = 4;
  // Window channel state
  typedef enum logic {W_OFF, W_ON} mtd_win_st_t;
  typedef struct packed {
    mtd_win_st_t st;
    logic [15:0] pcnt;
    logic [15:0] tcnt;
    logic [15:0] ncnt;
  } mtd_wch_t;
  typedef struct packed {
    mtd_wch_t [1:0] ch;
  } mtd_win_state_t;
  // Serial loader state
  typedef struct packed {
    logic clk_prev;
    logic sel_prev;
    logic [7:0] shreg;
    logic [3:0] cnt;
    logic [7:0] word;
    logic load;
  } mtd_ser_state_t;
  // Top state
  typedef struct packed {
    logic [11:0] div;
    logic tick;
    logic [1:0] res;
    logic [1:0] oe;
    logic [15:0] win_len;
    logic [15:0] on_thr;
    logic [15:0] off_thr;
    logic [IRQ_W-1:0] int_stat;
    logic [IRQ_W-1:0] int_en;
    logic [7:0] cfg;
    logic [1:0] band;
    logic [5:0] sens;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } mtd_top_state_t;
endpackage

// ---- shared/mtd_core_if.sv ----
// Links between the top and its window and serial loader modules
`timescale 1ns/10ps
interface mtd_core_if;
  logic tick;
  logic [1:0] tone;
  logic [15:0] win_len;
  logic [15:0] on_thr;
  logic [15:0] off_thr;
  logic [1:0] win_res;
  logic ser_en;
  logic sel_n;
  logic ser_clk;
  logic ser_data;
  logic [7:0] cfg_word;
  logic cfg_load;
  modport core (
    output tick, tone, win_len, on_thr, off_thr, ser_en, sel_n, ser_clk, ser_data,
    input win_res, cfg_word, cfg_load
  );
  modport win (
    input tick, tone, win_len, on_thr, off_thr,
    output win_res
  );
  modport ser (
    input ser_en, sel_n, ser_clk, ser_data,
    output cfg_word, cfg_load
  );
endinterface

// ---- rtl/mtd_window.sv ----
// Windowed respond and release logic for both channels
`timescale 1ns/10ps
module mtd_window (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // Core link
  mtd_core_if.win bus
);
  mtd_pkg::mtd_win_state_t st_reg;
  mtd_pkg::mtd_win_state_t st_next;

  always_comb begin
    logic [15:0] t;
    logic [15:0] n;
    t = 16'h0000;
    n = 16'h0000;
    st_next = st_reg;
    for (int i = 0; i < 2; i++) begin
      if (bus.tick) begin
        t = st_reg.ch[i].tcnt + (bus.tone[i] ? 16'h0001 : 16'h0000);
        n = st_reg.ch[i].ncnt + (bus.tone[i] ? 16'h0000 : 16'h0001);
        st_next.ch[i].tcnt = t;
        st_next.ch[i].ncnt = n;
        st_next.ch[i].pcnt = st_reg.ch[i].pcnt + 16'h0001;
        if (st_reg.ch[i].st == mtd_pkg::W_OFF && t >= bus.on_thr) begin
          st_next.ch[i].st = mtd_pkg::W_ON;
          st_next.ch[i].tcnt = 16'h0000;
          st_next.ch[i].ncnt = 16'h0000;
        end else if (st_reg.ch[i].st == mtd_pkg::W_ON && n >= bus.off_thr) begin
          st_next.ch[i].st = mtd_pkg::W_OFF;
          st_next.ch[i].tcnt = 16'h0000;
          st_next.ch[i].ncnt = 16'h0000;
        end
        if (st_reg.ch[i].pcnt + 16'h0001 >= bus.win_len) begin
          st_next.ch[i].pcnt = 16'h0000;
          st_next.ch[i].tcnt = 16'h0000;
          st_next.ch[i].ncnt = 16'h0000;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.win_res[0] = (st_reg.ch[0].st == mtd_pkg::W_ON);
  assign bus.win_res[1] = (st_reg.ch[1].st == mtd_pkg::W_ON);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_WIN_TICK_ONLY: assert property (!bus.tick |=> $stable(bus.win_res))
    else $error("window result changed without a tick");
  AST_WIN_NO_EARLY_ON: assert property (
    (bus.tick && !bus.win_res[0] && st_reg.ch[0].tcnt + 16'h0001 < bus.on_thr)
    |=> !bus.win_res[0])
    else $error("window result rose before tone count reached threshold");
  COV_WIN_ON: cover property ($rose(bus.win_res[0]));
endmodule

// ---- rtl/mtd_serial.sv ----
// Serial settings loader, chip select low, data taken on serial clock rise
`timescale 1ns/10ps
module mtd_serial (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // Core link
  mtd_core_if.ser bus
);
  mtd_pkg::mtd_ser_state_t st_reg;
  mtd_pkg::mtd_ser_state_t st_next;
  logic rise;

  assign rise = bus.ser_clk && !st_reg.clk_prev;

  always_comb begin
    st_next = st_reg;
    st_next.clk_prev = bus.ser_clk;
    st_next.sel_prev = bus.sel_n;
    st_next.load = 1'b0;
    if (bus.ser_en && !bus.sel_n && rise) begin
      st_next.shreg = {st_reg.shreg[6:0], bus.ser_data};
      if (st_reg.cnt != 4'hf) begin
        st_next.cnt = st_reg.cnt + 4'h1;
      end
    end
    if (bus.ser_en && bus.sel_n && !st_reg.sel_prev && st_reg.cnt == mtd_pkg::SER_BITS) begin
      st_next.word = st_reg.shreg;
      st_next.load = 1'b1;
    end
    if (bus.sel_n) begin
      st_next.cnt = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.cfg_word = st_reg.word;
  assign bus.cfg_load = st_reg.load;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SER_SHIFT: assert property (
    (bus.ser_en && !bus.sel_n && rise)
    |=> st_reg.shreg[0] == $past(bus.ser_data))
    else $error("serial bit not captured on clock rise");
  AST_SER_IDLE: assert property ((bus.sel_n || !bus.ser_en) |=> !$changed(st_reg.shreg))
    else $error("serial shift while not selected");
  COV_SER_LOAD: cover property (bus.cfg_load);
endmodule

// ---- rtl/mtd_top.sv ----
// Dual metering tone output logic with APB registers
`timescale 1ns/10ps
module mtd_top (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // APB slave
  input logic [7:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Detector decodes
  input logic [1:0] tone_valid,
  // Mode pins
  input logic out_hiz,
  input logic fmt_follow,
  input logic preset_fixed,
  input logic band_12k,
  // Serial settings pins
  input logic sel_n,
  input logic ser_clk,
  input logic ser_data,
  // Result pins
  output logic first_result_out,
  output logic first_result_oe,
  output logic second_result_out,
  output logic second_result_oe,
  // Channel settings
  output logic [1:0] ch_band,
  output logic [5:0] ch_sens
);
  mtd_pkg::mtd_top_state_t r;
  mtd_pkg::mtd_top_state_t n;
  mtd_core_if bus ();
  logic [1:0] res;
  logic [mtd_pkg::IRQ_W-1:0] ev;
  logic [mtd_pkg::IRQ_W-1:0] clr;
  logic [31:0] rdata;
  logic rerr;
  logic wr_acc;

  mtd_window u_window (
    .pclk(pclk),
    .presetn(presetn),
    .bus(bus.win)
  );

  mtd_serial u_serial (
    .pclk(pclk),
    .presetn(presetn),
    .bus(bus.ser)
  );

  // Core link drive
  assign bus.tick = r.tick;
  assign bus.tone = tone_valid;
  assign bus.win_len = r.win_len;
  assign bus.on_thr = r.on_thr;
  assign bus.off_thr = r.off_thr;
  assign bus.ser_en = !preset_fixed;
  assign bus.sel_n = sel_n;
  assign bus.ser_clk = ser_clk;
  assign bus.ser_data = ser_data;

  // Result format select, shared by both channels
  assign res = fmt_follow ? tone_valid : bus.win_res;

  // Interrupt events
  assign ev[mtd_pkg::EV_RISE +: 2] = res & ~r.res;
  assign ev[mtd_pkg::EV_FALL +: 2] = ~res & r.res;
  assign ev[mtd_pkg::EV_LOAD] = bus.cfg_load && !preset_fixed;

  // APB access phase write strobe
  assign wr_acc = psel && penable && r.pready && pwrite;
  assign clr = (wr_acc && paddr == mtd_pkg::OFF_INT_CLR) ?
               pwdata[mtd_pkg::IRQ_W-1:0] : '0;

  // Read decode
  always_comb begin
    rdata = 32'h0000_0000;
    rerr = 1'b0;
    case (paddr)
      mtd_pkg::OFF_WIN_LEN: begin
        rdata = {16'h0000, r.win_len};
      end
      mtd_pkg::OFF_WIN_THR: begin
        rdata = {r.off_thr, r.on_thr};
      end
      mtd_pkg::OFF_STATUS: begin
        rdata = {19'h0_0000, out_hiz, r.sens, r.band, preset_fixed, fmt_follow, r.res};
      end
      mtd_pkg::OFF_INT_STAT: begin
        rdata = {27'h000_0000, r.int_stat};
      end
      mtd_pkg::OFF_INT_CLR: begin
        rdata = 32'h0000_0000;
      end
      mtd_pkg::OFF_INT_EN: begin
        rdata = {27'h000_0000, r.int_en};
      end
      default: begin
        rerr = 1'b1;
      end
    endcase
  end

  // Next state
  always_comb begin
    n = r;
    // Tick divider from the single clock
    n.tick = 1'b0;
    if (r.div == mtd_pkg::TICK_MAX) begin
      n.div = 12'h000;
      n.tick = 1'b1;
    end else begin
      n.div = r.div + 12'h001;
    end
    // Result pins
    n.res = res;
    n.oe = out_hiz ? 2'b00 : 2'b11;
    // Settings source
    if (!preset_fixed && bus.cfg_load) begin
      n.cfg = bus.cfg_word;
    end
    if (preset_fixed) begin
      n.band = {2{band_12k}};
      n.sens = {2{mtd_pkg::FIX_SENS}};
    end else begin
      n.band = {r.cfg[mtd_pkg::CH_CFG_W + mtd_pkg::CFG_BAND_BIT],
                r.cfg[mtd_pkg::CFG_BAND_BIT]};
      n.sens = {r.cfg[6:4], r.cfg[2:0]};
    end
    // APB setup and access phases
    n.pready = 1'b0;
    if (psel && !penable) begin
      n.pready = 1'b1;
      n.prdata = pwrite ? 32'h0000_0000 : rdata;
      n.pslverr = rerr;
    end
    if (wr_acc) begin
      case (paddr)
        mtd_pkg::OFF_WIN_LEN: begin
          n.win_len = pwdata[15:0];
        end
        mtd_pkg::OFF_WIN_THR: begin
          n.on_thr = pwdata[15:0];
          n.off_thr = pwdata[mtd_pkg::THR_OFF_LSB +: 16];
        end
        mtd_pkg::OFF_INT_EN: begin
          n.int_en = pwdata[mtd_pkg::IRQ_W-1:0];
        end
        default: begin
          n.int_en = r.int_en;
        end
      endcase
    end
    // Sticky status, a new event wins over a clear
    n.int_stat = (r.int_stat & ~clr) | ev;
    n.irq = |(n.int_stat & n.int_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.win_len <= mtd_pkg::WIN_LEN_RST;
      r.on_thr <= mtd_pkg::ON_THR_RST;
      r.off_thr <= mtd_pkg::OFF_THR_RST;
      r.cfg <= mtd_pkg::CFG_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
  assign first_result_out = r.res[0];
  assign second_result_out = r.res[1];
  assign first_result_oe = r.oe[0];
  assign second_result_oe = r.oe[1];
  assign ch_band = r.band;
  assign ch_sens = r.sens;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_HIZ_BOTH: assert property (out_hiz |=> !first_result_oe && !second_result_oe)
    else $error("result outputs driven while gate high");
  AST_DRIVE_BOTH: assert property (!out_hiz |=> first_result_oe && second_result_oe)
    else $error("result outputs not driven while gate low");
  AST_FOLLOW: assert property (
    fmt_follow |=> first_result_out == $past(tone_valid[0]) &&
                   second_result_out == $past(tone_valid[1]))
    else $error("follower output differs from decode");
  AST_WINDOWED: assert property (
    !fmt_follow |=> first_result_out == $past(bus.win_res[0]) &&
                    second_result_out == $past(bus.win_res[1]))
    else $error("windowed output differs from window result");
  AST_TICK_SPACE: assert property (r.tick |=> !r.tick [*8])
    else $error("tick pulses too close");
  AST_FIXED_BAND: assert property (preset_fixed |=> ch_band == {2{$past(band_12k)}})
    else $error("fixed band not taken from band pin");
  AST_SER_CFG: assert property (
    (!preset_fixed && bus.cfg_load) |=> r.cfg == $past(bus.cfg_word))
    else $error("serial settings not taken");
  AST_FIXED_KEEP: assert property (preset_fixed |=> $stable(r.cfg))
    else $error("settings changed by serial load in fixed mode");
  AST_APB_READY: assert property ((psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
  AST_IRQ: assert property (|(r.int_stat & r.int_en) |-> irq)
    else $error("enabled status without interrupt");

  COV_FOLLOW_HIGH: cover property (fmt_follow && first_result_out && first_result_oe);
  COV_HIZ: cover property ($rose(out_hiz));
  COV_IRQ: cover property ($rose(irq));
endmodule

// ---- bench/mtd_host_model.sv ----
// Host model that loads channel settings over the serial pins
`timescale 1ns/10ps
module mtd_host_model (
  // Clock
  input wire logic pclk,
  // Serial pins
  output logic sel_n,
  output logic ser_clk,
  output logic ser_data
);
  initial begin
    sel_n = 1'b1;
    ser_clk = 1'b0;
    ser_data = 1'b0;
  end
  // Sends the top n bits of b, MSB first; clock idles low between frames
  task automatic send(input logic [7:0] b, input int n);
    @(posedge pclk) sel_n <= 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge pclk) ser_data <= b[i];
      repeat (2) @(posedge pclk);
      ser_clk <= 1'b1;
      repeat (2) @(posedge pclk);
      ser_clk <= 1'b0;
    end
    repeat (2) @(posedge pclk);
    sel_n <= 1'b1;
    ser_data <= ~ser_data;
  endtask
endmodule

// ---- bench/mtd_top_tb_top.sv ----
// Self-checking testbench for the dual metering tone output logic
`timescale 1ns/10ps
module mtd_top_tb_top;
  localparam int TK = 2500;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] tone_valid, ch_band;
  logic [5:0] ch_sens;
  logic out_hiz, fmt_follow, preset_fixed, band_12k, sel_n, ser_clk, ser_data;
  logic r1, o1, r2, o2;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  mtd_top mtd_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .tone_valid(tone_valid), .out_hiz(out_hiz),
    .fmt_follow(fmt_follow), .preset_fixed(preset_fixed), .band_12k(band_12k),
    .sel_n(sel_n), .ser_clk(ser_clk), .ser_data(ser_data), .first_result_out(r1),
    .first_result_oe(o1), .second_result_out(r2), .second_result_oe(o2),
    .ch_band(ch_band), .ch_sens(ch_sens));
  mtd_host_model mtd_host_model_i (.pclk(pclk), .sel_n(sel_n), .ser_clk(ser_clk),
    .ser_data(ser_data));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic give_verdict;
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      give_verdict;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic look(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic e_exp);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    #1;
    while (pready !== 1'b1) begin
      @(posedge pclk);
      #1;
    end
    rd = prdata;
    chk({31'h0, pslverr}, {31'h0, e_exp}, "slave error");
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_reset;
    chk({26'h0, o1, o2, r1, r2, irq, pready}, 32'h0, "outputs in reset");
    @(posedge pclk) presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 1'b0);
    chk(rd, 32'h0000_0190, "period reset");
    apb(1'b0, 8'h04, 32'h0, 1'b0);
    chk(rd, 32'h00c8_00c8, "threshold reset");
    apb(1'b1, 8'h40, 32'h0000_ffff, 1'b1);
    apb(1'b0, 8'h40, 32'h0, 1'b1);
    chk(rd, 32'h0, "unmapped read");
  endtask

  task automatic t_gate;
    @(posedge pclk) out_hiz <= 1'b1;
    look(2);
    chk({30'h0, o1, o2}, 32'h0, "gate high");
    @(posedge pclk) out_hiz <= 1'b0;
    look(2);
    chk({30'h0, o1, o2}, 32'h3, "gate low");
  endtask

  task automatic t_follow;
    logic [1:0] p[4] = '{2'b01, 2'b10, 2'b11, 2'b00};
    @(posedge pclk) fmt_follow <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk) tone_valid <= p[i];
      look(2);
      chk({30'h0, r2, r1}, {30'h0, p[i]}, "follower result");
    end
  endtask

  task automatic t_irq;
    apb(1'b1, 8'h10, 32'h0000_001f, 1'b0);
    apb(1'b1, 8'h14, 32'h0, 1'b0);
    @(posedge pclk) tone_valid <= 2'b01;
    look(3);
    chk({31'h0, irq}, 32'h0, "masked irq");
    apb(1'b0, 8'h0c, 32'h0, 1'b0);
    chk(rd & 32'h0000_0001, 32'h1, "rise event");
    apb(1'b1, 8'h14, 32'h0000_0001, 1'b0);
    look(1);
    chk({31'h0, irq}, 32'h1, "enabled irq");
    apb(1'b1, 8'h10, 32'h0000_0001, 1'b0);
    look(1);
    chk({31'h0, irq}, 32'h0, "cleared irq");
    @(posedge pclk) tone_valid <= 2'b00;
  endtask

  task automatic t_fixed;
    @(posedge pclk) preset_fixed <= 1'b1;
    band_12k <= 1'b1;
    look(3);
    chk({24'h0, ch_band, ch_sens}, 32'h0000_00c0, "fixed 12k");
    @(posedge pclk) band_12k <= 1'b0;
    look(3);
    chk({24'h0, ch_band, ch_sens}, 32'h0, "fixed 16k");
  endtask

  task automatic t_serial;
    @(posedge pclk) preset_fixed <= 1'b0;
    band_12k <= 1'b1;
    mtd_host_model_i.send(8'h5a, 8);
    look(6);
    chk({24'h0, ch_band, ch_sens}, 32'h0000_006a, "serial load");
    mtd_host_model_i.send(8'ha5, 7);
    look(6);
    chk({24'h0, ch_band, ch_sens}, 32'h0000_006a, "short load");
    apb(1'b0, 8'h0c, 32'h0, 1'b0);
    chk(rd & 32'h0000_0010, 32'h0000_0010, "load event");
  endtask

  task automatic t_window;
    @(posedge pclk) fmt_follow <= 1'b0;
    apb(1'b1, 8'h00, 32'h0000_0008, 1'b0);
    apb(1'b1, 8'h04, 32'h0003_0003, 1'b0);
    look(6 * TK);
    chk({30'h0, r2, r1}, 32'h0, "window idle");
    @(posedge pclk) tone_valid <= 2'b01;
    look(2 * TK);
    chk({30'h0, r2, r1}, 32'h0, "early respond");
    look(4 * TK);
    chk({30'h0, r2, r1}, 32'h1, "respond");
    @(posedge pclk) tone_valid <= 2'b00;
    look(2 * TK);
    chk({30'h0, r2, r1}, 32'h1, "early release");
    look(4 * TK);
    chk({30'h0, r2, r1}, 32'h0, "release");
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, out_hiz, fmt_follow, preset_fixed, band_12k} = 7'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tone_valid = 2'b00;
    look(3);
    t_reset;
    t_gate;
    t_follow;
    t_irq;
    t_fixed;
    t_serial;
    t_window;
    give_verdict;
  end
endmodule
